/* hdl/ptbr_regs.sv */
`timescale 1ns/100ps
// test, self-test and soft reset control registers of one transceiver port
module ptbr_regs #(
   parameter int TALLY_WIDTH  = 8,
   parameter int BURST_CYCLES = 64
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [15:0] reg_rdata,
   input  wire logic        speed_100,
   input  wire logic        full_duplex,
   input  wire logic        selftest_start,
   input  wire logic        selftest_active,
   input  wire logic        rx_nibble_error,
   output logic             heartbeat_enable,
   output logic             jabber_enable,
   output logic             selftest_nonstop,
   output logic             tx_no_gap,
   output logic             driver_pattern_on_ten,
   output logic      [1:0]  driver_pattern_choice,
   output logic             pattern_sending,
   output logic             core_soft_reset,
   output logic             irq
);
   initial begin
      if (TALLY_WIDTH != 8) $error("selftest tally must be 8 bits");
   end

   typedef struct packed {
      logic        heartbeat_dis;
      logic        jabber_dis;
      logic [2:0]  tenbase_misc;
      logic [7:0]  selftest_fault_tally;
      logic        selftest_nonstop;
      logic        driver_pattern_on_ten;
      logic        pattern_spacing_sel;
      logic [1:0]  driver_pattern_choice;
      logic        srst_active;
      logic [4:0]  srst_count;
      logic [2:0]  irq_status;
      logic [2:0]  irq_mask;
      logic [15:0] rdata;
   } ptbr_state_t;

   ptbr_state_t st, next_st;
   ptbr_patt_if patt ();
   logic        wr_tenbase;
   logic        wr_cdtest;
   logic        wr_phy_general_control_two;
   logic        wr_status;
   logic        wr_mask;
   logic [2:0]  irq_event;
   logic        srst_end;

   // write decode
   always_comb begin
      wr_tenbase = 1'b0;
      wr_cdtest  = 1'b0;
      wr_phy_general_control_two  = 1'b0;
      wr_status  = 1'b0;
      wr_mask    = 1'b0;
      if (!reg_write) begin
         wr_tenbase = 1'b0;
      end else if (reg_addr == ptbr_pkg::ADDR_TENBASE) begin
         wr_tenbase = 1'b1;
      end else if (reg_addr == ptbr_pkg::ADDR_CDTEST) begin
         wr_cdtest = 1'b1;
      end else if (reg_addr == ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO) begin
         wr_phy_general_control_two = 1'b1;
      end else if (reg_addr == ptbr_pkg::ADDR_IRQ_STATUS) begin
         wr_status = 1'b1;
      end else if (reg_addr == ptbr_pkg::ADDR_IRQ_MASK) begin
         wr_mask = 1'b1;
      end
   end

   assign srst_end = st.srst_active && (st.srst_count == 5'h00);

   // events: tally saturating, soft reset finished, one test sequence done
   assign irq_event[ptbr_pkg::IRQ_SATURATED] = selftest_active && rx_nibble_error
                                               && !selftest_start
                                               && (st.selftest_fault_tally
                                                   == ptbr_pkg::TALLY_MAX - 8'h01);
   assign irq_event[ptbr_pkg::IRQ_SRST_DONE] = srst_end;
   assign irq_event[ptbr_pkg::IRQ_SEQ_DONE]  = patt.seq_done;

   // next state of every register; the soft reset leaves configuration alone
   always_comb begin
      next_st = st;
      if (wr_tenbase) begin
         next_st.heartbeat_dis = reg_wdata[ptbr_pkg::BIT_HEARTBEAT];
         next_st.jabber_dis    = reg_wdata[ptbr_pkg::BIT_JABBER_DIS];
         next_st.tenbase_misc  = reg_wdata[4:2];
      end
      if (wr_cdtest) begin
         next_st.selftest_nonstop      = reg_wdata[ptbr_pkg::BIT_NONSTOP];
         next_st.driver_pattern_on_ten = reg_wdata[ptbr_pkg::BIT_PATT_EN];
         next_st.pattern_spacing_sel   = reg_wdata[ptbr_pkg::BIT_GAP_SEL];
         next_st.driver_pattern_choice = reg_wdata[1:0];
      end
      if (selftest_start) begin
         next_st.selftest_fault_tally = 8'h00;
      end else if (selftest_active && rx_nibble_error) begin
         if (st.selftest_fault_tally != ptbr_pkg::TALLY_MAX) begin
            next_st.selftest_fault_tally = st.selftest_fault_tally + 8'h01;
         end
      end
      // only bit 9 of this register is writable
      if (wr_phy_general_control_two && reg_wdata[ptbr_pkg::BIT_SOFT_RESET] && !st.srst_active) begin
         next_st.srst_active = 1'b1;
         next_st.srst_count  = 5'(ptbr_pkg::SRST_CYCLES - 1);
      end else if (srst_end) begin
         next_st.srst_active = 1'b0;
      end else if (st.srst_active) begin
         next_st.srst_count = st.srst_count - 5'h01;
      end
      // write-one-to-clear; a new event in the same cycle wins
      if (wr_status) begin
         next_st.irq_status = st.irq_status & ~reg_wdata[2:0];
      end
      next_st.irq_status = next_st.irq_status | irq_event;
      if (wr_mask) begin
         next_st.irq_mask = reg_wdata[2:0];
      end
      // read data stands only in the cycle after the strobe
      next_st.rdata = 16'h0000;
      if (!reg_read) begin
         next_st.rdata = 16'h0000;
      end else if (reg_addr == ptbr_pkg::ADDR_TENBASE) begin
         next_st.rdata = {11'h000, st.tenbase_misc, st.heartbeat_dis, st.jabber_dis};
      end else if (reg_addr == ptbr_pkg::ADDR_CDTEST) begin
         next_st.rdata = {st.selftest_fault_tally, 2'b00, st.selftest_nonstop,
                          st.driver_pattern_on_ten, 1'b0, st.pattern_spacing_sel,
                          st.driver_pattern_choice};
      end else if (reg_addr == ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO) begin
         next_st.rdata = {6'h00, st.srst_active, 9'h000};
      end else if (reg_addr == ptbr_pkg::ADDR_IRQ_STATUS) begin
         next_st.rdata = {13'h0000, st.irq_status};
      end else if (reg_addr == ptbr_pkg::ADDR_IRQ_MASK) begin
         next_st.rdata = {13'h0000, st.irq_mask};
      end
   end

   // state register; configuration fields take their documented reset values
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st              <= '0;
         st.tenbase_misc <= ptbr_pkg::TENBASE_RESET[4:2];
      end else begin
         st <= next_st;
      end
   end

   // pattern sequencer runs under the soft reset as device logic
   assign patt.enable   = st.driver_pattern_on_ten;
   assign patt.long_gap = st.pattern_spacing_sel;

   ptbr_patt_seq #(
      .BURST_CYCLES (BURST_CYCLES)
   ) u_seq (
      .clock    (clock),
      .rst_n    (rst_n),
      .soft_rst (st.srst_active),
      .patt     (patt.gen)
   );

   // heartbeat in half duplex 10 Mb
   // forced off at 100 Mb or full duplex
   assign heartbeat_enable      = !speed_100 && !full_duplex && !st.heartbeat_dis;
   assign jabber_enable         = !speed_100 && !st.jabber_dis;
   assign selftest_nonstop      = st.selftest_nonstop;
   assign tx_no_gap             = st.selftest_nonstop && selftest_active;
   assign driver_pattern_on_ten = st.driver_pattern_on_ten;
   assign driver_pattern_choice = st.driver_pattern_on_ten ? st.driver_pattern_choice : 2'b00;
   assign pattern_sending       = patt.sending;
   assign core_soft_reset       = st.srst_active;
   assign reg_rdata             = st.rdata;
   assign irq                   = |(st.irq_status & st.irq_mask);

   a_heartbeat_follow: assert property (@(posedge clock) disable iff (!rst_n)
      (!speed_100 && !full_duplex) |-> (heartbeat_enable == !st.heartbeat_dis))
      else $error("heartbeat not following disable bit");
   a_heartbeat_off: assert property (@(posedge clock) disable iff (!rst_n)
      (speed_100 || full_duplex) |-> !heartbeat_enable)
      else $error("heartbeat on at 100 Mb or full duplex");
   a_jabber_follow: assert property (@(posedge clock) disable iff (!rst_n)
      (!speed_100 && reg_write && reg_addr == ptbr_pkg::ADDR_TENBASE)
      ##1 !speed_100 |-> jabber_enable == !$past(reg_wdata[0]))
      else $error("jabber enable not following bit");
   a_tally_count: assert property (@(posedge clock) disable iff (!rst_n)
      (selftest_active && rx_nibble_error && !selftest_start
       && st.selftest_fault_tally != 8'hFF)
      |=> st.selftest_fault_tally == $past(st.selftest_fault_tally) + 8'h01)
      else $error("tally missed an error");
   a_tally_clear: assert property (@(posedge clock) disable iff (!rst_n)
      selftest_start |=> st.selftest_fault_tally == 8'h00)
      else $error("tally not cleared on restart");
   a_tally_stick: assert property (@(posedge clock) disable iff (!rst_n)
      (st.selftest_fault_tally == 8'hFF && !selftest_start)
      |=> st.selftest_fault_tally == 8'hFF)
      else $error("tally left saturation");
   a_nonstop_gap: assert property (@(posedge clock) disable iff (!rst_n)
      tx_no_gap |-> (selftest_nonstop && selftest_active))
      else $error("gapless transmit outside continuous test");
   a_srst_keep: assert property (@(posedge clock) disable iff (!rst_n)
      (st.srst_active && !reg_write) |=> $stable(st.heartbeat_dis)
      && $stable(st.jabber_dis) && $stable(st.driver_pattern_choice))
      else $error("configuration changed by soft reset");
   a_srst_clear: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(core_soft_reset) |-> core_soft_reset [*8] ##[1:12] !core_soft_reset)
      else $error("soft reset did not clear itself");
   a_phy_general_control_two_zero: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_read && reg_addr == ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO)
      |=> (reg_rdata & 16'hFDFF) == 16'h0000)
      else $error("reserved bits not zero");
   a_srst_readback: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_read && reg_addr == ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO)
      |=> reg_rdata[9] == $past(core_soft_reset))
      else $error("soft reset bit readback wrong");

   a_heartbeat_bit: assert property (@(posedge clock) disable iff (!rst_n)
      st.heartbeat_dis |-> !heartbeat_enable)
      else $error("heartbeat on with disable bit set");

   a_tenbase_read: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_read && reg_addr == ptbr_pkg::ADDR_TENBASE)
      |=> reg_rdata[1:0] == $past({st.heartbeat_dis, st.jabber_dis}))
      else $error("heartbeat or jabber bit readback wrong");

   a_jabber_fast: assert property (@(posedge clock) disable iff (!rst_n)
      speed_100 |-> !jabber_enable)
      else $error("jabber active at 100 Mb");

   a_tally_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (!selftest_start && !(selftest_active && rx_nibble_error))
      |=> $stable(st.selftest_fault_tally))
      else $error("tally moved without an error");

   a_tally_read: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_read && reg_addr == ptbr_pkg::ADDR_CDTEST)
      |=> reg_rdata[15:8] == $past(st.selftest_fault_tally))
      else $error("tally readback wrong");

   a_sat_flag: assert property (@(posedge clock) disable iff (!rst_n)
      (st.selftest_fault_tally == 8'hFE && selftest_active && rx_nibble_error
       && !selftest_start) |=> st.irq_status[ptbr_pkg::IRQ_SATURATED])
      else $error("saturation flag not set");

   a_nonstop_idle: assert property (@(posedge clock) disable iff (!rst_n)
      !selftest_active |-> !tx_no_gap)
      else $error("gapless transmit without a self-test run");

   a_patt_stop: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(driver_pattern_on_ten) |=> !pattern_sending)
      else $error("pattern kept running after disable");

   a_burst_hold: assert property (@(posedge clock) disable iff (!rst_n)
      ($rose(pattern_sending) && driver_pattern_on_ten && !core_soft_reset)
      |=> pattern_sending)
      else $error("burst ended after one cycle");

   a_gap_hold: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(pattern_sending) |=> !pattern_sending [*8])
      else $error("gap shorter than eight cycles");

   a_choice_gated: assert property (@(posedge clock) disable iff (!rst_n)
      !driver_pattern_on_ten |-> driver_pattern_choice == 2'b00)
      else $error("pattern choice shown while disabled");

   a_choice_pass: assert property (@(posedge clock) disable iff (!rst_n)
      driver_pattern_on_ten |-> driver_pattern_choice == st.driver_pattern_choice)
      else $error("pattern choice not passed on");

   a_srst_start: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_write && reg_addr == ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO && reg_wdata[9]
       && !core_soft_reset) |=> core_soft_reset)
      else $error("soft reset not started");

   a_srst_seq_idle: assert property (@(posedge clock) disable iff (!rst_n)
      core_soft_reset |=> !pattern_sending)
      else $error("sequencer ran during soft reset");

   a_srst_count: assert property (@(posedge clock) disable iff (!rst_n)
      core_soft_reset |-> st.srst_count <= 5'h0F)
      else $error("soft reset counter out of range");

   // read data idle when not read
   a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n)
      !reg_read |=> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
endmodule // ptbr_regs

/* shared/ptbr_pkg.sv */
// Summary of operation
// - half-duplex 10 Mb: heartbeat suppressed when bit 1 set, performed when clear.
// - at 100 Mb or full duplex, heartbeat bit ignored, heartbeat off.
// - 10BASE-T only: jabber disabled when bit 0 set, active when clear.
// - packet self-test counts each errored received nibble in bits 15:8.
// - error counter clears to zero when self-test starts again.
// - error counter sticks at its maximum until self-test restarts.
// - continuous bit 5 makes transmit pseudo-random data with no gaps.
// - continuous mode works together with the main self-test controls.
// - 10 Mb test pattern sent only while pattern-enable bit 4 is set.
// - gap between test sequences is 15 us when bit 2 set, else 10 us.
// - pattern selector: 00 data end_of_packet_type_zero, 01 data end_of_packet_type_one, 10 link pulses, 11 ones.
// - writing soft-reset bit 9 resets the logic but keeps all registers.
// - soft-reset bit clears itself without a software write.
// - reserved bits of control register two ignore writes and read zero.
package ptbr_pkg;
   localparam logic [4:0]  ADDR_TENBASE    = 5'h1A;
   localparam logic [4:0]  ADDR_CDTEST     = 5'h1B;
   localparam logic [4:0]  ADDR_PHY_GENERAL_CONTROL_ONE_TWO  = 5'h1C;
   localparam logic [4:0]  ADDR_IRQ_STATUS = 5'h1E;
   localparam logic [4:0]  ADDR_IRQ_MASK   = 5'h1F;
   // field positions
   localparam int          BIT_JABBER_DIS  = 0;
   localparam int          BIT_HEARTBEAT   = 1;
   localparam int          BIT_GAP_SEL     = 2;
   localparam int          BIT_PATT_EN     = 4;
   localparam int          BIT_NONSTOP     = 5;
   localparam int          BIT_SOFT_RESET  = 9;
   localparam int          TALLY_LSB       = 8;
   // reset values and tally limit
   localparam logic [15:0] TENBASE_RESET   = 16'h0004;
   localparam logic [7:0]  TALLY_MAX       = 8'hFF;
   // soft reset pulse length, in cycles
   localparam int          SRST_CYCLES     = 16;
   // test gap times in ns and cycles at 200 MHz
   localparam int          CLK_PERIOD_NS   = 5;
   localparam int          GAP_SHORT_NS    = 10000;
   localparam int          GAP_LONG_NS     = 15000;
   localparam int          GAP_SHORT_CYC   = GAP_SHORT_NS / CLK_PERIOD_NS;
   localparam int          GAP_LONG_CYC    = GAP_LONG_NS / CLK_PERIOD_NS;
   // interrupt status bits
   localparam int          IRQ_SATURATED   = 0;
   localparam int          IRQ_SRST_DONE   = 1;
   localparam int          IRQ_SEQ_DONE    = 2;
   typedef enum logic [1:0] {
      PTBR_PATT_END_OF_PACKET_TYPE_ZERO,
      PTBR_PATT_END_OF_PACKET_TYPE_ONE,
      PTBR_PATT_NLP,
      PTBR_PATT_ONES
   } ptbr_patt_t;
endpackage

/* shared/ptbr_patt_if.sv */
`timescale 1ns/100ps
// pattern sequencer control and status between the register bank and the timer
interface ptbr_patt_if;
   logic        enable;
   logic        long_gap;
   logic        sending;
   logic        seq_done;
   modport ctrl (output enable, output long_gap, input sending, input seq_done);
   modport gen  (input enable, input long_gap, output sending, output seq_done);
endinterface

/* hdl/ptbr_patt_seq.sv */
`timescale 1ns/100ps
// alternates a test sequence burst with the selected gap while enabled
module ptbr_patt_seq #(
   parameter int BURST_CYCLES = 64
) (
   input  wire logic   clock,
   input  wire logic   rst_n,
   input  wire logic   soft_rst,
   ptbr_patt_if.gen    patt
);
   initial begin
      if (BURST_CYCLES < 1 || BURST_CYCLES > 65535) $error("BURST_CYCLES out of range");
   end
   typedef struct packed {
      logic        sending;
      logic        done;
      logic [15:0] count;
   } ptbr_seq_t;
   ptbr_seq_t st, next_st;

   // gap length follows the select bit at the start of every gap
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (!patt.enable || soft_rst) begin
         next_st.sending = 1'b0;
         next_st.count   = 16'h0000;
      end else if (st.count != 16'h0000) begin
         next_st.count = st.count - 16'h0001;
      end else if (st.sending) begin
         next_st.sending = 1'b0;
         next_st.done    = 1'b1;
         next_st.count   = patt.long_gap ? 16'(ptbr_pkg::GAP_LONG_CYC - 1)
                                         : 16'(ptbr_pkg::GAP_SHORT_CYC - 1);
      end else begin
         next_st.sending = 1'b1;
         next_st.count   = 16'(BURST_CYCLES - 1);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign patt.sending  = st.sending;
   assign patt.seq_done = st.done;

   a_patt_off_idle: assert property (@(posedge clock) disable iff (!rst_n)
      !patt.enable |=> !patt.sending) else $error("pattern sent while disabled");
endmodule // ptbr_patt_seq

/* dv/testbench.sv */
`timescale 1ns/100ps
// register bank bench: tasks speak the strobe bus, tests are call sequences
module testbench;
   logic        clock;
   logic        rst_n;
   logic [4:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_write;
   logic        reg_read;
   logic [15:0] reg_rdata;
   logic        speed_100;
   logic        full_duplex;
   logic        selftest_start;
   logic        selftest_active;
   logic        rx_nibble_error;
   logic        heartbeat_enable;
   logic        jabber_enable;
   logic        selftest_nonstop;
   logic        tx_no_gap;
   logic        driver_pattern_on_ten;
   logic [1:0]  driver_pattern_choice;
   logic        pattern_sending;
   logic        core_soft_reset;
   logic        irq;
   int          miscompares = 0;
   int          num_checks = 0;
   logic [15:0] rd;
   int          n;

   ptbr_regs #(.TALLY_WIDTH(8), .BURST_CYCLES(64)) uut (
      .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .speed_100(speed_100), .full_duplex(full_duplex), .selftest_start(selftest_start),
      .selftest_active(selftest_active), .rx_nibble_error(rx_nibble_error),
      .heartbeat_enable(heartbeat_enable), .jabber_enable(jabber_enable),
      .selftest_nonstop(selftest_nonstop), .tx_no_gap(tx_no_gap),
      .driver_pattern_on_ten(driver_pattern_on_ten),
      .driver_pattern_choice(driver_pattern_choice), .pattern_sending(pattern_sending),
      .core_soft_reset(core_soft_reset), .irq(irq));

   // 200 MHz clock
   always #2.5 clock = ~clock;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one-cycle write strobe, effect visible just after the sampling edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask

   // read data stands only in the cycle after the strobe edge
   task automatic rdreg(input logic [4:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // counts cycles that pattern_sending holds one level, bounded
   task automatic run_len(input logic lvl, output int cnt);
      cnt = 0;
      while (pattern_sending === lvl && cnt < 5000) begin
         @(posedge clock);
         #1;
         cnt++;
      end
   endtask

   // err picks the nibble error input, otherwise the self-test start input
   task automatic pulse(input bit err, input int cycles);
      @(posedge clock);
      if (err) begin
         rx_nibble_error <= 1'b1;
      end else begin
         selftest_start <= 1'b1;
      end
      repeat (cycles) @(posedge clock);
      rx_nibble_error <= 1'b0;
      selftest_start  <= 1'b0;
   endtask

   // watchdog: whole sequence needs roughly 5700 cycles
   initial begin
      #(30000 * 5);
      miscompares++;
      finish_test();
   end

   // main sequence
   initial begin
      {clock, rst_n, reg_write, reg_read, speed_100, full_duplex} = '0;
      {selftest_start, selftest_active, rx_nibble_error} = '0;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rdreg(ptbr_pkg::ADDR_TENBASE, rd); check(rd, ptbr_pkg::TENBASE_RESET, "tenbase reset");
      rdreg(ptbr_pkg::ADDR_CDTEST, rd); check(rd, 16'h0000, "cdtest reset");
      rdreg(ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO, rd); check(rd, 16'h0000, "ctrl two reset");
      $display("test reset done");

      // every speed, duplex and disable-bit combination
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         speed_100   <= i[3];
         full_duplex <= i[2];
         wr(ptbr_pkg::ADDR_TENBASE, {14'h0001, i[1], i[0]});
         check(16'(heartbeat_enable), 16'(!i[3] && !i[2] && !i[1]), "heartbeat");
         check(16'(jabber_enable), 16'(!i[3] && !i[0]), "jabber");
      end
      rdreg(ptbr_pkg::ADDR_TENBASE, rd); check(rd, 16'h0007, "tenbase readback");
      $display("test heartbeat jabber done");

      // each pattern code, then disabled selector reads as zero
      for (int s = 0; s < 4; s++) begin
         wr(ptbr_pkg::ADDR_CDTEST, 16'h0010 | 16'(s));
         check(16'(driver_pattern_choice), 16'(s), "pattern choice");
         check(16'(driver_pattern_on_ten), 16'h0001, "pattern enable");
      end
      wr(ptbr_pkg::ADDR_CDTEST, 16'h0002);
      check(16'(driver_pattern_choice), 16'h0000, "choice when off");
      check(16'(driver_pattern_on_ten), 16'h0000, "pattern off");
      $display("test pattern select done");

      // burst then 10 us gap, then 15 us gap
      wr(ptbr_pkg::ADDR_CDTEST, 16'h0010);
      run_len(1'b0, n);
      run_len(1'b1, n); check(16'(n), 16'd64, "burst length");
      run_len(1'b0, n); check(16'(n), 16'(ptbr_pkg::GAP_SHORT_CYC), "short gap");
      wr(ptbr_pkg::ADDR_CDTEST, 16'h0014);
      run_len(1'b1, n);
      run_len(1'b0, n); check(16'(n), 16'(ptbr_pkg::GAP_LONG_CYC), "long gap");
      wr(ptbr_pkg::ADDR_CDTEST, 16'h0004);
      repeat (70) @(posedge clock);
      #1;
      check(16'(pattern_sending), 16'h0000, "no burst when off");
      $display("test pattern gap done");

      // nonstop mode, reserved bits, error tally count, saturation, restart
      // jabber-disable is still set from the last combination above
      check(16'(uut.st.jabber_dis), 16'h0001, "jabber off first");
      wr(ptbr_pkg::ADDR_CDTEST, 16'h00E8);
      @(posedge clock);
      selftest_active <= 1'b1;
      pulse(1'b0, 1);
      #1;
      check(16'(selftest_nonstop), 16'h0001, "nonstop out");
      check(16'(tx_no_gap), 16'h0001, "no gap tx");
      pulse(1'b1, 5);
      rdreg(ptbr_pkg::ADDR_CDTEST, rd); check(rd, 16'h0520, "tally five");
      pulse(1'b1, 300);
      rdreg(ptbr_pkg::ADDR_CDTEST, rd); check(rd, 16'hFF20, "tally sticks");
      rdreg(ptbr_pkg::ADDR_IRQ_STATUS, rd); check(rd & 16'h0001, 16'h0001, "saturate flag");
      pulse(1'b0, 1);
      rdreg(ptbr_pkg::ADDR_CDTEST, rd); check(rd, 16'h0020, "tally restart");
      pulse(1'b1, 2);
      rdreg(ptbr_pkg::ADDR_CDTEST, rd); check(rd, 16'h0220, "tally recount");
      $display("test selftest done");

      // soft reset pulse length, self clear, configuration kept
      wr(ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO, 16'hFFFF);
      n = 0;
      while (core_soft_reset === 1'b1 && n < 100) begin
         n++;
         @(posedge clock);
         #1;
      end
      check(16'(n), 16'(ptbr_pkg::SRST_CYCLES), "soft reset length");
      wr(ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO, 16'h0200);
      rdreg(ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO, rd); check(rd, 16'h0200, "bit 9 during");
      repeat (20) @(posedge clock);
      rdreg(ptbr_pkg::ADDR_PHY_GENERAL_CONTROL_ONE_TWO, rd); check(rd, 16'h0000, "bit 9 cleared");
      rdreg(ptbr_pkg::ADDR_CDTEST, rd); check(rd, 16'h0220, "cdtest kept");
      rdreg(ptbr_pkg::ADDR_TENBASE, rd); check(rd, 16'h0007, "tenbase kept");
      $display("test soft reset done");

      // interrupt masked, unmasked, cleared; unmapped address
      check(16'(irq), 16'h0000, "irq masked");
      wr(ptbr_pkg::ADDR_IRQ_MASK, 16'h0002);
      check(16'(irq), 16'h0001, "irq raised");
      wr(ptbr_pkg::ADDR_IRQ_STATUS, 16'h0002);
      check(16'(irq), 16'h0000, "irq cleared");
      rdreg(ptbr_pkg::ADDR_IRQ_STATUS, rd); check(rd & 16'h0002, 16'h0000, "status cleared");
      wr(5'h05, 16'hFFFF);
      rdreg(5'h05, rd); check(rd, 16'h0000, "unmapped");
      $display("test interrupt done");
      finish_test();
   end
endmodule // testbench
